// ===== selog_pkg.sv
// Purpose : shared constants and carriers for the error and phy event log pages
// Assumes : byte-wide page stream, 16-bit phy event counters
// Notes   : multi-byte fields are least significant byte first
package selog_pkg;
  // ----------------------------------------------------------------
  // page geometry
  // ----------------------------------------------------------------
  localparam int unsigned PAGE_BYTES  = 512;
  localparam logic [8:0]  IDX_LAST    = 9'h01FF;
  localparam logic [8:0]  IDX_CNT_LO  = 9'h0004;
  localparam logic [8:0]  IDX_CNT_HI  = 9'h0017;
  localparam logic [8:0]  IDX_SNAP_HI = 9'h000D;
  localparam logic [8:0]  IDX_TERM_LO = 9'h0018;
  localparam logic [8:0]  IDX_TERM_HI = 9'h0019;
  localparam int unsigned NQ_BIT      = 7;
  // ----------------------------------------------------------------
  // phy event counters
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CNT  = 5;
  localparam int unsigned CNT_W    = 16;
  localparam logic [3:0]  SIZE_16  = 4'h1;
  localparam logic [11:0] ID_ICRC  = 12'h001;
  localparam logic [11:0] ID_NRDY  = 12'h009;
  localparam logic [11:0] ID_SIG   = 12'h00A;
  localparam logic [11:0] ID_RXCRC = 12'h00B;
  localparam logic [11:0] ID_RXERR = 12'h00D;
  localparam logic [11:0] ID_END   = 12'h000;
  localparam int unsigned FIFO_DEPTH = 8;

  typedef enum logic {SELOG_PAGE_CMDERR, SELOG_PAGE_PHYEV} selog_page_e;
  typedef enum logic {SELOG_IDLE, SELOG_GEN} selog_state_e;

  // event order matches the counter order in the page
  typedef struct packed {
    logic rx_other_err;
    logic rx_crc_err;
    logic sig_fis_sent;
    logic phy_not_ready;
    logic icrc_fail;
  } selog_events_s;

  typedef struct packed {
    logic       queued;
    logic [4:0] tag;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] device;
    logic [7:0] lba_low_prev;
    logic [7:0] lba_mid_prev;
    logic [7:0] lba_high_prev;
    logic [7:0] count;
    logic [7:0] count_prev;
  } selog_err_s;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } selog_beat_s;
endpackage

// ===== selog_log.sv
// Purpose : phy event counters and generator of the two 512-byte log pages
// Assumes : all inputs synchronous to clk; event inputs are one-cycle pulses
// Notes   : page bytes pass through a small fifo so the reader can stall
//
// Behaviour
// - queued errors put the queue tag in byte 0 bits 4..0 of error page.
// - byte 0 bit 7 set means non-queued; cleared means tag is valid.
// - bytes 2..13 hold the shadow registers captured when the error was reported.
// - error page bytes: status, error, lba, device, previous lba, counts; rest zero.
// - last byte of each page is the two's complement of the first 511.
// - counters start cleared after power-up reset.
// - link or software resets leave the counters unchanged.
// - a bist activate fis clears every phy event counter.
// - reading the phy page with clear set returns values then clears counters.
// - each phy page entry is a 16-bit identifier then the counter value.
// - identifier bits 14..12 give counter size; 1h means 16 bits.
// - codes 001h icrc fail, 009h phy not ready, 00Ah signature fis.
// - codes 00Bh received crc errors, 00Dh received non-crc errors.
// - identifier 000h with no value ends the counter list.
// - transmitted counts items sent to host, received counts items from host.
// - phy page: zero bytes 0..3, five entries from byte 4, terminator 24..25.
`timescale 1ns/1ps

module selog_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // output word is a register so the top drives its pins from flops
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= AW'(wr_r + 1'b1);
      end
      if (pop) begin
        rd_r <= AW'(rd_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem_r[rd_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  a_fifo_bound : assert property (@(posedge clk) disable iff (!reset_n)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
  c_fifo_full : cover property (@(posedge clk) disable iff (!reset_n) !in_ready);
endmodule

module selog_log
  import selog_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire selog_events_s events,
  input  wire logic          bist_activate,
  input  wire logic          err_report,
  input  wire selog_err_s    err_info,
  input  wire logic          page_req,
  input  wire selog_page_e   page_sel,
  input  wire logic          page_clear,
  output logic [7:0]         out_data,
  output logic               out_last,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic               busy
);
  selog_state_e          state_r;
  selog_page_e           page_r;
  selog_err_s            err_r;
  logic [CNT_W-1:0]      cnt_r  [NUM_CNT];
  logic [CNT_W-1:0]      snap_r [NUM_CNT];
  logic [8:0]            idx_r;
  logic [7:0]            sum_r;
  logic [7:0]            byte_nxt;
  logic                  start;
  logic                  rd_clear;
  logic                  push;
  logic                  fifo_ready;
  selog_beat_s           beat_in;
  selog_beat_s           beat_out;
  logic [NUM_CNT-1:0]    ev_vec;
  logic [11:0]           id_code [NUM_CNT];

  assign ev_vec  = events;
  assign id_code = '{ID_ICRC, ID_NRDY, ID_SIG, ID_RXCRC, ID_RXERR};
  assign start    = (state_r == SELOG_IDLE) && page_req;
  assign rd_clear = start && (page_sel == SELOG_PAGE_PHYEV) && page_clear;
  assign push     = (state_r == SELOG_GEN) && fifo_ready;

  // ----------------------------------------------------------------
  // phy event counters
  // ----------------------------------------------------------------
  // of the resets only the power-up reset touches them; link resets have no input here
  // a clear in the same cycle as an event keeps that event (count of one)
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        cnt_r[i] <= '0;
      end else if (bist_activate || rd_clear) begin
        cnt_r[i] <= CNT_W'(ev_vec[i]);
      end else if (ev_vec[i] && (cnt_r[i] != '1)) begin
        cnt_r[i] <= CNT_W'(cnt_r[i] + 1'b1);
      end
    end

    // page reports values as they stood when the read was taken
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        snap_r[i] <= '0;
      end else if (start) begin
        snap_r[i] <= cnt_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // error snapshot
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      err_r <= '0;
    end else if (err_report) begin
      err_r <= err_info;
    end
  end

  // ----------------------------------------------------------------
  // page sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= SELOG_IDLE;
      page_r  <= SELOG_PAGE_CMDERR;
      idx_r   <= '0;
      sum_r   <= '0;
    end else begin
      case (state_r)
        SELOG_IDLE: begin
          if (page_req) begin
            state_r <= SELOG_GEN;
            page_r  <= page_sel;
            idx_r   <= '0;
            sum_r   <= '0;
          end
        end
        SELOG_GEN: begin
          if (push) begin
            sum_r <= 8'(sum_r + byte_nxt);
            idx_r <= 9'(idx_r + 1'b1);
            if (idx_r == IDX_LAST) begin
              state_r <= SELOG_IDLE;
            end
          end
        end
        default: begin
          state_r <= SELOG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_r == SELOG_GEN) && !(push && (idx_r == IDX_LAST)) || start;
    end
  end

  // ----------------------------------------------------------------
  // byte generator
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0]  off;
    logic [15:0] word;
    int unsigned ent;
    off      = 9'(idx_r - IDX_CNT_LO);
    ent      = int'(off[8:2]);
    word     = '0;
    byte_nxt = 8'h00;
    if (idx_r == IDX_LAST) begin
      byte_nxt = 8'(-sum_r);
    end else if (page_r == SELOG_PAGE_CMDERR) begin
      case (idx_r)
        9'h000: begin
          byte_nxt[NQ_BIT] = !err_r.queued;
          byte_nxt[4:0]    = err_r.queued ? err_r.tag : 5'h00;
        end
        9'h002: byte_nxt = err_r.status;
        9'h003: byte_nxt = err_r.error;
        9'h004: byte_nxt = err_r.lba_low;
        9'h005: byte_nxt = err_r.lba_mid;
        9'h006: byte_nxt = err_r.lba_high;
        9'h007: byte_nxt = err_r.device;
        9'h008: byte_nxt = err_r.lba_low_prev;
        9'h009: byte_nxt = err_r.lba_mid_prev;
        9'h00A: byte_nxt = err_r.lba_high_prev;
        9'h00C: byte_nxt = err_r.count;
        9'h00D: byte_nxt = err_r.count_prev;
        default: byte_nxt = 8'h00;
      endcase
    end else if ((idx_r >= IDX_CNT_LO) && (idx_r <= IDX_CNT_HI)) begin
      // entry: identifier word then value word, each low byte first
      if (off[1]) begin
        word = snap_r[ent];
      end else begin
        word = {1'b0, SIZE_16[2:0], id_code[ent]};
      end
      byte_nxt = off[0] ? word[15:8] : word[7:0];
    end else begin
      byte_nxt = {ID_END[7:0] & 8'h00};
    end
  end

  assign beat_in.data = byte_nxt;
  assign beat_in.last = (idx_r == IDX_LAST);

  selog_fifo #(
    .WIDTH ($bits(selog_beat_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (beat_in),
    .in_valid  (state_r == SELOG_GEN),
    .in_ready  (fifo_ready),
    .out_data  (beat_out),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

  assign out_data = beat_out.data;
  assign out_last = beat_out.last;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // sum of the bytes the reader really took, so a lost or doubled fifo word shows up
  logic [7:0] chk_sum_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chk_sum_r <= '0;
    end else if (out_valid && out_ready) begin
      chk_sum_r <= out_last ? 8'h00 : 8'(chk_sum_r + out_data);
    end
  end

  a_page_cksum : assert property (@(posedge clk) disable iff (!reset_n)
    out_valid && out_ready && out_last |-> 8'(chk_sum_r + out_data) == 8'h00)
    else $error("page bytes do not sum to zero");
  // generator checks look at each byte as it enters the fifo
  a_tag_byte : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_CMDERR && idx_r == 9'h000 && err_r.queued
    |-> byte_nxt == {3'b000, err_r.tag}) else $error("queue tag byte wrong");
  a_nq_flag : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_CMDERR && idx_r == 9'h000 && !err_r.queued
    |-> byte_nxt == 8'h80) else $error("non-queued flag byte wrong");
  a_snap_status : assert property (@(posedge clk) disable iff (!reset_n)
    err_report ##1 (!err_report)[*2] |-> err_r == $past(err_info, 2))
    else $error("shadow snapshot not held");
  a_id_word : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_PHYEV && (idx_r == IDX_CNT_LO || idx_r == 9'h005)
    |-> byte_nxt == (idx_r[0] ? 8'h10 : 8'h01)) else $error("first identifier word wrong");
  a_term_zero : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_PHYEV
    && (idx_r == IDX_TERM_LO || idx_r == IDX_TERM_HI) |-> byte_nxt == 8'h00)
    else $error("terminator not zero");
  a_bist_clear : assert property (@(posedge clk) disable iff (!reset_n)
    bist_activate |=> cnt_r[0] == CNT_W'($past(ev_vec[0])))
    else $error("bist did not clear counter");
  a_read_clear : assert property (@(posedge clk) disable iff (!reset_n)
    rd_clear |=> snap_r[1] == $past(cnt_r[1]) && cnt_r[1] == CNT_W'($past(ev_vec[1])))
    else $error("read-and-clear wrong");
  a_count_step : assert property (@(posedge clk) disable iff (!reset_n)
    ev_vec[2] && !bist_activate && !rd_clear && cnt_r[2] != '1
    |=> cnt_r[2] == CNT_W'($past(cnt_r[2]) + 1'b1)) else $error("event not counted");
  a_count_hold : assert property (@(posedge clk) disable iff (!reset_n)
    !ev_vec[3] && !bist_activate && !rd_clear |=> $stable(cnt_r[3]))
    else $error("counter changed without cause");
  a_cmd_reserved : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_CMDERR && idx_r != IDX_LAST
    && (idx_r == 9'h001 || idx_r == 9'h00B || idx_r > IDX_SNAP_HI) |-> byte_nxt == 8'h00)
    else $error("reserved error page byte not zero");
  a_phy_head : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_PHYEV && idx_r < IDX_CNT_LO |-> byte_nxt == 8'h00)
    else $error("phy page header not zero");
  a_value_word : assert property (@(posedge clk) disable iff (!reset_n)
    push && page_r == SELOG_PAGE_PHYEV && idx_r == 9'h006
    |-> byte_nxt == snap_r[0][7:0]) else $error("first counter value misplaced");
  a_sat_hold : assert property (@(posedge clk) disable iff (!reset_n)
    ev_vec[0] && cnt_r[0] == '1 && !bist_activate && !rd_clear
    |=> cnt_r[0] == '1) else $error("counter wrapped past full scale");
  a_busy_flag : assert property (@(posedge clk) disable iff (!reset_n)
    start |=> busy) else $error("busy not raised on request");

  c_cmd_page : cover property (@(posedge clk) disable iff (!reset_n)
    push && beat_in.last && page_r == SELOG_PAGE_CMDERR);
  c_phy_clear : cover property (@(posedge clk) disable iff (!reset_n) rd_clear);
  c_bist : cover property (@(posedge clk) disable iff (!reset_n)
    bist_activate && cnt_r[4] != '0);
  c_stall : cover property (@(posedge clk) disable iff (!reset_n)
    state_r == SELOG_GEN && !fifo_ready);
endmodule

// ===== selog_reader.sv
// Purpose : host-side reader of one log page from the byte stream
// Assumes : page bytes arrive with valid/ready, out_last marks the final byte
// Notes   : stall mode holds ready low long enough to fill the fifo, then throttles
`timescale 1ns/1ps

module selog_reader
  import selog_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  start,
  input  wire logic  stall,
  input  wire logic  [7:0] out_data,
  input  wire logic  out_last,
  input  wire logic  out_valid,
  output logic       out_ready,
  output logic [7:0] page [512],
  output logic [9:0] n_bytes,
  output logic       done
);
  logic [7:0] cyc_r;

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (start) begin
      n_bytes <= 10'h000;
      done    <= 1'b0;
      cyc_r   <= 8'h00;
    end else begin
      if (cyc_r != 8'hFF) cyc_r <= cyc_r + 8'h01;
      if (out_valid && out_ready && !done) begin
        page[n_bytes[8:0]] <= out_data;
        n_bytes            <= n_bytes + 10'h001;
        if (out_last) done <= 1'b1;
      end
    end
  end

  // ready moves at the falling edge, like every other bench-driven input
  always @(negedge clk) begin
    out_ready <= reset_n && (!stall || (cyc_r > 8'h18 && cyc_r[1:0] != 2'h0));
  end
endmodule

// ===== tb_selog_log.sv
// Purpose : self-checking bench for the error and phy event log pages
// Assumes : 25 MHz clock, inputs change at the falling edge
// Notes   : expected pages are built here from the page layouts
`timescale 1ns/1ps

module tb_selog_log;
  import selog_pkg::*;
  logic          clk, reset_n, bist_activate, err_report, page_req, page_clear;
  logic          start, stall, out_last, out_valid, out_ready, busy, done;
  selog_events_s events;
  selog_err_s    err_info;
  selog_page_e   page_sel;
  logic [7:0]    out_data;
  logic [7:0]    pg [512];
  logic [7:0]    exp_pg [512];
  logic [9:0]    n_bytes;
  logic [4:0][15:0] cnt;
  int            n_fail, checks_done;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  selog_log DUT (.clk(clk), .reset_n(reset_n), .events(events),
    .bist_activate(bist_activate), .err_report(err_report), .err_info(err_info),
    .page_req(page_req), .page_sel(page_sel), .page_clear(page_clear),
    .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
    .out_ready(out_ready), .busy(busy));

  selog_reader rdr (.clk(clk), .reset_n(reset_n), .start(start), .stall(stall),
    .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
    .out_ready(out_ready), .page(pg), .n_bytes(n_bytes), .done(done));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    checks_done++;
    if (seen !== expv) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
  endtask

  task automatic pulse(input logic [4:0] ev, input int n);
    repeat (n) begin
      @(negedge clk);
      events = ev;
      @(negedge clk);
      events = '0;
    end
  endtask

  // a second request while busy must be ignored: exactly one page comes out
  task automatic read_page(input selog_page_e sel, input logic clr, input logic stl);
    int k;
    logic [7:0] s;
    @(negedge clk);
    page_req = 1'b1; page_sel = sel; page_clear = clr; start = 1'b1; stall = stl;
    @(negedge clk);
    start = 1'b0; page_sel = SELOG_PAGE_CMDERR; page_clear = 1'b1;
    chk({15'h0000, busy}, 16'h0001);
    @(negedge clk);
    page_req = 1'b0; page_clear = 1'b0;
    k = 0;
    while (!done && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (!done) begin
      n_fail++;
      $display("[ERR] %0t page read timed out", $time);
    end
    repeat (20) @(negedge clk);
    chk({6'h00, n_bytes}, 16'h0200);
    chk({15'h0000, out_valid}, 16'h0000);
    chk({15'h0000, busy}, 16'h0000);
    s = 8'h00;
    for (k = 0; k < 512; k++) s += pg[k];
    chk({8'h00, s}, 16'h0000);
  endtask

  task automatic seal_exp();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 511; i++) s += exp_pg[i];
    exp_pg[511] = -s;
  endtask

  task automatic phy_exp();
    logic [15:0] ids [5];
    ids = '{16'h1001, 16'h1009, 16'h100A, 16'h100B, 16'h100D};
    for (int i = 0; i < 512; i++) exp_pg[i] = 8'h00;
    for (int j = 0; j < 5; j++) begin
      exp_pg[4+4*j] = ids[j][7:0];
      exp_pg[5+4*j] = ids[j][15:8];
      exp_pg[6+4*j] = cnt[j][7:0];
      exp_pg[7+4*j] = cnt[j][15:8];
    end
    seal_exp();
  endtask

  task automatic cmp_page();
    for (int i = 0; i < 512; i++) chk({8'h00, pg[i]}, {8'h00, exp_pg[i]});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic scn_counts();
    for (int j = 0; j < 5; j++) pulse(5'h01 << j, j + 1);
    pulse(5'h1F, 1);
    read_page(SELOG_PAGE_PHYEV, 1'b1, 1'b1);
    cnt = {16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002};
    phy_exp();
    cmp_page();
    read_page(SELOG_PAGE_PHYEV, 1'b0, 1'b0);
    cnt = '0;
    phy_exp();
    cmp_page();
  endtask

  task automatic scn_bist();
    pulse(5'h11, 3);
    @(negedge clk);
    bist_activate = 1'b1;
    events = 5'h10;
    @(negedge clk);
    bist_activate = 1'b0;
    events = '0;
    read_page(SELOG_PAGE_PHYEV, 1'b0, 1'b0);
    cnt = {16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    phy_exp();
    cmp_page();
  endtask

  task automatic scn_power();
    pulse(5'h03, 2);
    @(negedge clk);
    do_reset();
    read_page(SELOG_PAGE_PHYEV, 1'b0, 1'b1);
    cnt = '0;
    phy_exp();
    cmp_page();
  endtask

  task automatic scn_err(input logic q, input logic [4:0] tag);
    @(negedge clk);
    err_info = {q, tag, 8'h51, 8'h84, 8'h11, 8'h22, 8'h33, 8'h40,
                8'h44, 8'h55, 8'h66, 8'h07, 8'h08};
    err_report = 1'b1;
    @(negedge clk);
    err_report = 1'b0;
    err_info = {~q, 5'h0A, {11{8'hEE}}};
    read_page(SELOG_PAGE_CMDERR, 1'b0, 1'b1);
    for (int i = 0; i < 512; i++) exp_pg[i] = 8'h00;
    exp_pg[0] = q ? {3'h0, tag} : 8'h80;
    exp_pg[2] = 8'h51; exp_pg[3] = 8'h84; exp_pg[4] = 8'h11; exp_pg[5] = 8'h22;
    exp_pg[6] = 8'h33; exp_pg[7] = 8'h40; exp_pg[8] = 8'h44; exp_pg[9] = 8'h55;
    exp_pg[10] = 8'h66; exp_pg[12] = 8'h07; exp_pg[13] = 8'h08;
    seal_exp();
    chk({8'h00, pg[0]}, {8'h00, exp_pg[0]});
    cmp_page();
  endtask

  initial begin
    reset_n = 1'b0; bist_activate = 1'b0; err_report = 1'b0; page_req = 1'b0;
    page_clear = 1'b0; start = 1'b0; stall = 1'b0; events = '0; err_info = '0;
    page_sel = SELOG_PAGE_CMDERR; n_fail = 0; checks_done = 0;
    do_reset();
    read_page(SELOG_PAGE_PHYEV, 1'b0, 1'b0);
    cnt = '0;
    phy_exp();
    cmp_page();
    scn_counts();
    scn_bist();
    scn_err(1'b1, 5'h13);
    scn_err(1'b0, 5'h1F);
    scn_power();
    wrap_up();
  end
endmodule
